// ---- adc_result_sequencing.sv ----
// converter control: sample counting, scan restart, result placement, pin config
`timescale 1ns/1ns
// What this block does
// R01 - samples-per-interrupt field bits 5..2 of control two sets interrupt spacing
// R02 - with scan select bit set, scan list restarts after the sample count
// R03 - without DMA, result write pointer returns to first buffer at count
// R04 - without DMA, results fill the first field plus one buffers in conversion order only
// R05 - with DMA, one result register overwritten by each new result
// R06 - done flag cleared at conversion start, set at completion, held
// R07 - software clears done just before setting the sample bit manually
// R08 - pin digital only when config bit is one in both converters
// R09 - conversion count reloads at field plus one, keeping pointer and scan aligned
module adc_result_sequencing #(
  parameter bit HAS_DMA = 1'b0,
  parameter int NUM_BUFS = 16,
  parameter int NUM_PINS = 32,
  parameter int RES_W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core, same clock
  input wire logic convStart,
  input wire logic convDone,
  input wire logic [RES_W-1:0] convResult,
  output logic [4:0] scanChannel,
  output logic sampleEnable,
  // pin configuration
  input wire logic [NUM_PINS-1:0] otherPinCfg,
  input wire logic [NUM_PINS-1:0] padDigitalIn,
  output logic [NUM_PINS-1:0] digitalEnable,
  output logic [NUM_PINS-1:0] altDigitalIn,
  // dma and interrupt
  output logic dmaRequest,
  output logic irq
);
  import adc_seq_pkg::*;

  logic [15:0] ctrlOne_q, ctrlOne_d;
  logic [15:0] ctrlTwo_q, ctrlTwo_d;
  logic [15:0] scanLow_q, scanLow_d;
  logic [15:0] scanHigh_q, scanHigh_d;
  logic [NUM_PINS-1:0] pinCfg_q, pinCfg_d;
  logic [1:0] irqStatus_q, irqStatus_d;
  logic [1:0] irqMask_q, irqMask_d;
  logic [3:0] convCount_q, convCount_d;
  logic [3:0] bufPtr_q, bufPtr_d;
  logic [4:0] scanPos_q, scanPos_d;
  logic unread_q, unread_d;
  logic [RES_W-1:0] resultMem_q [NUM_BUFS];
  logic [RES_W-1:0] resultMem_d [NUM_BUFS];
  logic [NUM_PINS-1:0] padSync1_q, padSync2_q;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d;

  logic wrEn, rdEn, countHit, mapped;
  logic [3:0] spiField;
  logic [31:0] scanMask;
  logic [4:0] nextScan;
  logic [3:0] bufIdx;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign spiField = ctrlTwo_q[SPI_LSB+3:SPI_LSB]; // R01
  assign countHit = convDone && (convCount_q == spiField); // R09
  assign scanMask = {scanHigh_q, scanLow_q};
  assign bufIdx = paddr[5:2];

  // next selected channel after the current one, wrapping to the list head
  always_comb begin
    nextScan = scanPos_q;
    for (int i = 31; i >= 1; i--) begin
      if (scanMask[(int'(scanPos_q) + i) % 32]) begin
        nextScan = 5'((int'(scanPos_q) + i) % 32);
      end
    end
  end

  function automatic logic [4:0] firstScan(input logic [31:0] m);
    logic [4:0] f;
    f = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        f = 5'(i);
      end
    end
    return f;
  endfunction

  // sequencing state
  always_comb begin
    convCount_d = convCount_q;
    bufPtr_d = bufPtr_q;
    scanPos_d = scanPos_q;
    if (convDone) begin
      if (countHit) begin
        convCount_d = 4'h0; // R09
        bufPtr_d = 4'h0; // R03
        if (ctrlTwo_q[SCAN_SEL_POS]) begin
          scanPos_d = firstScan(scanMask); // R02
        end
      end else begin
        convCount_d = convCount_q + 4'h1;
        bufPtr_d = bufPtr_q + 4'h1; // R04
        if (ctrlTwo_q[SCAN_SEL_POS]) begin
          scanPos_d = nextScan;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      convCount_q <= 4'h0;
      bufPtr_q <= 4'h0;
      scanPos_q <= 5'h00;
    end else begin
      convCount_q <= convCount_d;
      bufPtr_q <= bufPtr_d;
      scanPos_q <= scanPos_d;
    end
  end

  // result storage: one entry per buffer, entry zero only when dma present
  genvar g;
  generate
    for (g = 0; g < NUM_BUFS; g++) begin : gBuf
      always_comb begin
        resultMem_d[g] = resultMem_q[g];
        if (convDone) begin
          if (HAS_DMA) begin
            if (g == 0) begin
              resultMem_d[g] = convResult; // R05
            end
          end else if (int'(bufPtr_q) == g) begin
            resultMem_d[g] = convResult; // R04
          end
        end
      end
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          resultMem_q[g] <= '0;
        end else begin
          resultMem_q[g] <= resultMem_d[g];
        end
      end
    end
  endgenerate

  // register file
  always_comb begin
    ctrlOne_d = ctrlOne_q;
    ctrlTwo_d = ctrlTwo_q;
    scanLow_d = scanLow_q;
    scanHigh_d = scanHigh_q;
    pinCfg_d = pinCfg_q;
    irqMask_d = irqMask_q;
    irqStatus_d = irqStatus_q;
    unread_d = unread_q;
    if (wrEn) begin
      if (paddr == OFF_CTRL_ONE) begin
        ctrlOne_d = pwdata[15:0]; // R07
      end else if (paddr == OFF_CTRL_TWO) begin
        ctrlTwo_d = pwdata[15:0];
      end else if (paddr == OFF_SCAN_LOW) begin
        scanLow_d = pwdata[15:0];
      end else if (paddr == OFF_SCAN_HIGH) begin
        scanHigh_d = pwdata[15:0];
      end else if (paddr == OFF_PIN_CFG) begin
        pinCfg_d = pwdata[NUM_PINS-1:0];
      end else if (paddr == OFF_IRQ_MASK) begin
        irqMask_d = pwdata[1:0];
      end
    end
    // read of status clears it; new events in the same cycle win
    if (rdEn && paddr == OFF_IRQ_STATUS) begin
      irqStatus_d = IRQ_RESET;
    end
    if (rdEn && paddr == OFF_BUF_BASE) begin
      unread_d = 1'b0;
    end
    // done flag: hardware start/done override software writes
    if (convStart) begin
      ctrlOne_d[DONE_POS] = 1'b0; // R06
    end
    if (convDone) begin
      ctrlOne_d[DONE_POS] = 1'b1; // R06
      if (HAS_DMA && unread_q) begin
        irqStatus_d[IRQ_OVR_POS] = 1'b1; // R05
      end
      unread_d = 1'b1;
    end
    if (countHit) begin
      irqStatus_d[IRQ_CONV_POS] = 1'b1; // R01
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOne_q <= CTRL_RESET;
      ctrlTwo_q <= CTRL_RESET;
      scanLow_q <= SCAN_RESET;
      scanHigh_q <= SCAN_RESET;
      pinCfg_q <= PIN_CFG_RESET;
      irqMask_q <= IRQ_RESET;
      irqStatus_q <= IRQ_RESET;
      unread_q <= 1'b0;
    end else begin
      ctrlOne_q <= ctrlOne_d;
      ctrlTwo_q <= ctrlTwo_d;
      scanLow_q <= scanLow_d;
      scanHigh_q <= scanHigh_d;
      pinCfg_q <= pinCfg_d;
      irqMask_q <= irqMask_d;
      irqStatus_q <= irqStatus_d;
      unread_q <= unread_d;
    end
  end

  // read data, registered in the setup cycle so the access phase is one cycle
  always_comb begin
    prdata_d = prdata_q;
    slverr_d = 1'b0;
    mapped = 1'b1;
    if (psel && !penable) begin
      prdata_d = 32'h00000000;
      if (paddr == OFF_CTRL_ONE) begin
        prdata_d = {16'h0000, ctrlOne_q};
      end else if (paddr == OFF_CTRL_TWO) begin
        prdata_d = {16'h0000, ctrlTwo_q};
      end else if (paddr == OFF_SCAN_LOW) begin
        prdata_d = {16'h0000, scanLow_q};
      end else if (paddr == OFF_SCAN_HIGH) begin
        prdata_d = {16'h0000, scanHigh_q};
      end else if (paddr == OFF_PIN_CFG) begin
        prdata_d[NUM_PINS-1:0] = pinCfg_q;
      end else if (paddr == OFF_IRQ_STATUS) begin
        prdata_d = {30'h0, irqStatus_q};
      end else if (paddr == OFF_IRQ_MASK) begin
        prdata_d = {30'h0, irqMask_q};
      end else if (paddr == OFF_STATE) begin
        prdata_d = {19'h0, scanPos_q, bufPtr_q, convCount_q};
      end else if (paddr[11:6] == OFF_BUF_BASE[11:6] && paddr[1:0] == 2'h0) begin
        prdata_d[RES_W-1:0] = resultMem_q[bufIdx];
        if (HAS_DMA && bufIdx != 4'h0) begin
          prdata_d = 32'h00000000;
        end
      end else begin
        mapped = 1'b0;
      end
      slverr_d = !mapped;
    end else if (psel && penable) begin
      slverr_d = slverr_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // pad inputs come from outside the clock domain
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      padSync1_q <= '0;
      padSync2_q <= '0;
    end else begin
      padSync1_q <= padDigitalIn;
      padSync2_q <= padSync1_q;
    end
  end

  assign digitalEnable = pinCfg_q & otherPinCfg; // R08
  assign altDigitalIn = padSync2_q & digitalEnable; // R08
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = slverr_q && psel && penable;
  assign scanChannel = scanPos_q;
  assign sampleEnable = ctrlOne_q[SAMPLE_POS];
  assign dmaRequest = HAS_DMA && unread_q;
  assign irq = |(irqStatus_q & irqMask_q);
endmodule

// ---- adc_seq_chk.sv ----
// checker for the converter sequencing block
`timescale 1ns/1ns
module adc_seq_chk #(
  parameter bit HAS_DMA = 1'b0,
  parameter int NUM_PINS = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // converter and pins
  input wire logic convDone,
  input wire logic [4:0] scanChannel,
  input wire logic sampleEnable,
  input wire logic [NUM_PINS-1:0] otherPinCfg,
  input wire logic [NUM_PINS-1:0] digitalEnable,
  input wire logic [NUM_PINS-1:0] altDigitalIn,
  input wire logic dmaRequest,
  input wire logic irq
);
  import adc_seq_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic acc;
  assign acc = psel && penable;
  cfg_both_a: assert property ((digitalEnable & ~otherPinCfg) == '0)
    else $error("pin digital without other cfg");
  alt_gate_a: assert property ((altDigitalIn & ~digitalEnable) == '0)
    else $error("alt input leaks");
  dma_off_a: assert property (!HAS_DMA |-> !dmaRequest)
    else $error("dma request without dma");
  scan_hold_a: assert property (!convDone && !(acc && pwrite) |=> $stable(scanChannel))
    else $error("scan moved without conversion");
  sample_wr_a: assert property (acc && pwrite && paddr == OFF_CTRL_ONE
    |=> sampleEnable == pwdata[SAMPLE_POS])
    else $error("sample bit not written");
  irq_rise_a: assert property ($rose(irq) |-> $past(convDone) || $past(acc))
    else $error("irq without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc))
    else $error("irq dropped by itself");
  slverr_ph_a: assert property (pslverr |-> acc)
    else $error("error outside access");
endmodule
bind adc_result_sequencing adc_seq_chk #(.HAS_DMA(HAS_DMA), .NUM_PINS(NUM_PINS)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .convDone(convDone), .scanChannel(scanChannel), .sampleEnable(sampleEnable),
  .otherPinCfg(otherPinCfg), .digitalEnable(digitalEnable),
  .altDigitalIn(altDigitalIn), .dmaRequest(dmaRequest), .irq(irq));

// ---- adc_seq_pkg.sv ----
// constants shared by the converter result sequencing block
package adc_seq_pkg;
  localparam logic [11:0] OFF_CTRL_ONE = 12'h000;
  localparam logic [11:0] OFF_CTRL_TWO = 12'h004;
  localparam logic [11:0] OFF_SCAN_LOW = 12'h008;
  localparam logic [11:0] OFF_SCAN_HIGH = 12'h00C;
  localparam logic [11:0] OFF_PIN_CFG = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_STATE = 12'h01C;
  localparam logic [11:0] OFF_BUF_BASE = 12'h040;
  localparam int DONE_POS = 0;
  localparam int SAMPLE_POS = 1;
  localparam int SPI_LSB = 2;
  localparam int SCAN_SEL_POS = 10;
  localparam int IRQ_CONV_POS = 0;
  localparam int IRQ_OVR_POS = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SCAN_RESET = 16'h0000;
  localparam logic [31:0] PIN_CFG_RESET = 32'h00000000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

// ---- tb.sv ----
// self-checking bench for the converter sequencing block
`timescale 1ns/1ns
module tb;
  import adc_seq_pkg::*;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, convStart = 0, convDone = 0, sampleEnable, dmaRequest, irq;
  logic [11:0] paddr = '0, convResult = '0;
  logic [31:0] pwdata = '0, prdata, lfsr = 32'hB4B85A9C, own;
  logic [31:0] otherPinCfg = '0, padDigitalIn = '0, digitalEnable, altDigitalIn;
  logic [4:0] scanChannel;
  logic [4:0] scanExp[5] = '{5'h02, 5'h05, 5'h00, 5'h00, 5'h02};
  logic [11:0] res[5];
  logic [32:0] notes[$];
  int err_total = 0, check_count = 0;
  always #5 core_clk = ~core_clk;
  adc_result_sequencing u_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convStart(convStart), .convDone(convDone),
    .convResult(convResult), .scanChannel(scanChannel), .sampleEnable(sampleEnable),
    .otherPinCfg(otherPinCfg), .padDigitalIn(padDigitalIn),
    .digitalEnable(digitalEnable), .altDigitalIn(altDigitalIn),
    .dmaRequest(dmaRequest), .irq(irq));
  function automatic logic [31:0] rnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(logic [32:0] seen, logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] exp);
    notes.push_back(exp);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic conv(logic [11:0] r);
    @(posedge core_clk);
    convDone <= 1'b1;
    convResult <= r;
    @(posedge core_clk);
    convDone <= 1'b0;
    // outputs settle after the launching edge
    @(negedge core_clk);
  endtask
  // read answers are compared when the access phase completes
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
      check({pslverr, prdata}, notes.pop_front());
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    // four samples per event, scan over channels 0, 2 and 5
    xfer(1'b1, OFF_SCAN_LOW, 32'h00000025);
    xfer(1'b1, OFF_CTRL_TWO, 32'h0000040C);
    xfer(1'b1, OFF_IRQ_MASK, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      lfsr = rnd(lfsr);
      res[i] = lfsr[11:0];
      conv(res[i]);
      check(33'(irq), 33'(i >= 3));
      check(33'(scanChannel), 33'(scanExp[i]));
    end
    for (int i = 0; i < 4; i++) begin
      rd(OFF_BUF_BASE + 12'(4 * i), 33'(i == 0 ? res[4] : res[i]));
    end
    rd(OFF_STATE, 33'h000000211);
    rd(OFF_IRQ_STATUS, 33'h000000001);
    @(negedge core_clk);
    check(33'(irq), 33'h0);
    check(33'(dmaRequest), 33'h0);
    // a masked event must stay silent until unmasked
    xfer(1'b1, OFF_IRQ_MASK, 32'h0);
    repeat (3) conv(12'h0AA);
    check(33'(irq), 33'h0);
    xfer(1'b1, OFF_IRQ_MASK, 32'h00000001);
    @(negedge core_clk);
    check(33'(irq), 33'h1);
    $display("sequencing test finished");
    rd(OFF_CTRL_ONE, 33'h000000001);
    xfer(1'b1, OFF_CTRL_ONE, 32'h0);
    xfer(1'b1, OFF_CTRL_ONE, 32'h00000002);
    @(negedge core_clk);
    check(33'(sampleEnable), 33'h1);
    @(posedge core_clk);
    convStart <= 1'b1;
    @(posedge core_clk);
    convStart <= 1'b0;
    rd(OFF_CTRL_ONE, 33'h000000002);
    conv(12'h555);
    rd(OFF_CTRL_ONE, 33'h000000003);
    $display("done flag test finished");
    own = rnd(lfsr);
    lfsr = rnd(own);
    otherPinCfg <= lfsr;
    padDigitalIn <= rnd(lfsr);
    xfer(1'b1, OFF_PIN_CFG, own);
    rd(OFF_PIN_CFG, 33'(own));
    repeat (3) @(posedge core_clk);
    check(33'(digitalEnable), 33'(own & lfsr));
    check(33'(altDigitalIn), 33'(own & lfsr & rnd(lfsr)));
    $display("pin config test finished");
    rd(12'h080, {1'b1, 32'h0});
    $display("decode test finished");
    report_and_stop();
  end
endmodule
